// ===== fttc_pkg.sv
// Package of register indices, field positions, reset values and timing counts for the fan and overlimit config block.
`default_nettype none
package fttc_pkg;
    // Clock rate and documented times, each in its own unit.
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned STEP_TIME_US = 22760;
    localparam int unsigned SLOW_TIME_MS = 1000;
    localparam int unsigned FAST_TIME_MS = 250;
    // Cycle counts derived from the times; all exceed 4096 and become top-level parameters.
    localparam int unsigned STEP_CYCLES = STEP_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned SLOW_CYCLES = SLOW_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned FAST_CYCLES = FAST_TIME_MS * 1000000 / CLK_PERIOD_NS;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] IDX_STATUS = 8'h42;
    localparam logic [7:0] IDX_CFG = 8'h78;
    localparam logic [7:0] IDX_VALUE = 8'h79;
    localparam logic [7:0] IDX_LIMIT = 8'h7a;
    localparam logic [7:0] IDX_PPR = 8'h80;
    localparam logic [7:0] IDX_MASK = 8'h81;
    localparam logic [7:0] IDX_LOCK = 8'h82;

    // Field positions and masks of the pin and tach configuration register.
    localparam int unsigned CFG_ALERT_BIT = 0;
    localparam int unsigned CFG_OVL_EN_BIT = 1;
    localparam int unsigned CFG_FAST_BIT = 3;
    localparam int unsigned CFG_CONT_LSB = 4;
    localparam logic [7:0] CFG_LOCKABLE = 8'h0f;
    localparam logic [7:0] CFG_WRITABLE = 8'hfb;

    // Status bit positions and the lock bit.
    localparam int unsigned ST_ASSERT_BIT = 0;
    localparam int unsigned ST_OVERTIME_BIT = 5;
    localparam int unsigned LOCK_BIT = 0;

    // Reset values.
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] PPR_RST = 8'h55;
    localparam logic [7:0] LIMIT_RST = 8'hff;
    localparam logic [7:0] ZERO_RST = 8'h00;

    // Duration counter: shown once it reaches two steps, saturates at its top.
    localparam logic [7:0] SHOW_COUNT_MIN = 8'h02;
    localparam logic [7:0] COUNT_MAX = 8'hff;

    // Pulses counted per revolution for a 2-bit field: code plus one.
    function automatic logic [2:0] fttc_ppr_pulses(input logic [1:0] code);
        fttc_ppr_pulses = {1'b0, code} + 3'h1;
    endfunction : fttc_ppr_pulses
endpackage : fttc_pkg
`default_nettype wire

// ===== fttc_ovl_timer.sv
// Overlimit assertion timer: step prescaler, saturating duration count and event pulses.
`timescale 1ns/1ns
`default_nettype none
module fttc_ovl_timer
    import fttc_pkg::*;
#(
    parameter int unsigned STEP_CYC = STEP_CYCLES
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic asserted,
    input wire logic value_read,
    input wire logic [7:0] limit,
    output logic [7:0] value,
    output logic assert_event,
    output logic overtime_event
);
    typedef struct packed {
        logic asserted_d;
        logic restart;
        logic flag;
        logic [7:0] count;
        logic [31:0] presc;
        logic assert_ev;
        logic over_ev;
    } fttc_tmr_state_t;

    fttc_tmr_state_t state_ff;
    fttc_tmr_state_t nxt_state;
    logic rise;

    assign rise = asserted & ~state_ff.asserted_d;

    // Next state; a new assertion is applied after a read clear so the set wins.
    always_comb begin
        nxt_state = state_ff;
        nxt_state.asserted_d = asserted;
        nxt_state.assert_ev = 1'b0;
        nxt_state.over_ev = 1'b0;
        if (value_read) begin
            nxt_state.flag = 1'b0;
            nxt_state.restart = 1'b1;
        end
        if (rise) begin
            nxt_state.flag = 1'b1;
            nxt_state.assert_ev = 1'b1;
            nxt_state.presc = 32'h0000_0000;
            if (state_ff.restart || value_read) begin
                nxt_state.count = ZERO_RST;
                nxt_state.restart = 1'b0;
            end
            nxt_state.over_ev = (limit == ZERO_RST);
        end else if (asserted) begin
            if (state_ff.presc == 32'(STEP_CYC - 1)) begin
                nxt_state.presc = 32'h0000_0000;
                if (state_ff.count != COUNT_MAX) begin
                    nxt_state.count = state_ff.count + 8'h01;
                    nxt_state.over_ev = (limit != ZERO_RST) && (state_ff.count >= limit);
                end
            end else begin
                nxt_state.presc = state_ff.presc + 32'h0000_0001;
            end
        end
    end

    // State register.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Short assertions show only the flag; longer ones show the whole count.
    assign value = (state_ff.count >= SHOW_COUNT_MIN) ? state_ff.count : {7'h00, state_ff.flag};
    assign assert_event = state_ff.assert_ev;
    assign overtime_event = state_ff.over_ev;

    a_upper_zero: assert property (@(posedge clock) disable iff (!arst_n)
        (state_ff.count < SHOW_COUNT_MIN) |-> (value[7:1] == 7'h00)) else $error("Upper value bits not zero.");
    a_flag_on_rise: assert property (@(posedge clock) disable iff (!arst_n)
        rise |=> state_ff.flag && assert_event) else $error("Assertion flag not set on rise.");
    a_count_saturates: assert property (@(posedge clock) disable iff (!arst_n)
        (state_ff.count == COUNT_MAX) && asserted && !rise |=> (state_ff.count == COUNT_MAX))
        else $error("Duration count wrapped.");
    a_zero_limit_now: assert property (@(posedge clock) disable iff (!arst_n)
        rise && (limit == ZERO_RST) |=> overtime_event) else $error("Zero limit did not alert at once.");
    c_long_assert: cover property (@(posedge clock) disable iff (!arst_n) overtime_event && (limit != ZERO_RST));
endmodule : fttc_ovl_timer
`default_nettype wire

// ===== fttc_rate_gen.sv
// Fan speed measurement rate generator with per-channel continuous mode.
`timescale 1ns/1ns
`default_nettype none
module fttc_rate_gen
    import fttc_pkg::*;
#(
    parameter int unsigned SLOW_CYC = SLOW_CYCLES,
    parameter int unsigned FAST_CYC = FAST_CYCLES
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic fast,
    input wire logic [3:0] cont,
    output logic [3:0] measure_start,
    output logic [3:0] pulse_stretch_enable
);
    typedef struct packed {
        logic [31:0] presc;
        logic start;
    } fttc_rate_state_t;

    fttc_rate_state_t state_ff;
    fttc_rate_state_t nxt_state;
    logic [31:0] last;

    // A count already past the fast end restarts the period at once when the rate rises, since the count is compared with >=.
    assign last = fast ? 32'(FAST_CYC - 1) : 32'(SLOW_CYC - 1);

    always_comb begin
        nxt_state = state_ff;
        nxt_state.start = 1'b0;
        if (state_ff.presc >= last) begin
            nxt_state.presc = 32'h0000_0000;
            nxt_state.start = 1'b1;
        end else begin
            nxt_state.presc = state_ff.presc + 32'h0000_0001;
        end
    end

    // State register.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Continuous channels need no start pulse and never stretch.
    assign measure_start = {4{state_ff.start}} & ~cont;
    assign pulse_stretch_enable = ~cont;

    a_period_reload: assert property (@(posedge clock) disable iff (!arst_n)
        state_ff.start |-> ($past(state_ff.presc) >= (fast ? 32'(FAST_CYC - 1) : 32'(SLOW_CYC - 1)))
        || $past(fast) != fast) else $error("Measurement started early.");
    c_fast_start: cover property (@(posedge clock) disable iff (!arst_n) state_ff.start && fast);
endmodule : fttc_rate_gen
`default_nettype wire

// ===== fttc_regs.sv
// Register bank for fan tach configuration, overlimit timer and shared pin selection.
// What this block does
// - Alert-select 1 makes shared pin the alert output; 0 makes it fan-two drive.
// - Config bit 1 enables overlimit function on its pin instead of 2.5 V monitoring.
// - Fast bit makes fan measurements repeat every 250 ms instead of each second.
// - Each continuous bit measures its fan continuously and stops pulse stretching.
// - With lock set, config bits 3:0 ignore writes; bits 7:4 stay writable.
// - Upper seven timer bits read zero until assertion exceeds 45.52 ms.
// - Timer bit 0 sets on overlimit assertion and clears when register is read.
// - Past 45.52 ms bit 0 is LSB of 8-bit count, 22.76 ms steps.
// - Duration above the 8-bit limit sets status bit 5.
// - Limit 0x00 raises the interrupt immediately on assertion.
// - Four 2-bit fields select one to four pulses per revolution, default two.
`timescale 1ns/1ns
`default_nettype none
module fttc_regs
    import fttc_pkg::*;
#(
    parameter int unsigned STEP_CYC = STEP_CYCLES,
    parameter int unsigned SLOW_CYC = SLOW_CYCLES,
    parameter int unsigned FAST_CYC = FAST_CYCLES
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    input wire logic thermal_overlimit_line_n,
    input wire logic second_fan_drive_output,
    output logic shared_pin_out,
    output logic shared_pin_oe,
    output logic overlimit_pin_enable,
    output logic voltage_monitor_enable,
    output logic fast_rate,
    output logic continuous_measure_one,
    output logic continuous_measure_two,
    output logic continuous_measure_three,
    output logic continuous_measure_four,
    output logic [3:0] measure_start,
    output logic [3:0] pulse_stretch_enable,
    output logic [2:0] pulse_count_first_fan,
    output logic [2:0] pulse_count_second_fan,
    output logic [2:0] pulse_count_third_fan,
    output logic [2:0] pulse_count_fourth_fan
);
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] ppr;
        logic [7:0] limit;
        logic [7:0] status;
        logic [7:0] mask;
        logic lock;
        logic ack;
        logic [31:0] rdata;
    } fttc_regs_state_t;

    fttc_regs_state_t state_ff;
    fttc_regs_state_t nxt_state;
    logic [7:0] idx;
    logic aligned;
    logic busy;
    logic wr_take;
    logic rd_take;
    logic value_read;
    logic ovl_asserted;
    logic [7:0] timer_value;
    logic assert_event;
    logic overtime_event;
    logic [7:0] rd_mux;

    // True when the access is an aligned word at the given register index.
    function automatic logic hits(input logic [7:0] a, input logic al, input logic [7:0] reg_idx);
        hits = al && (a == reg_idx);
    endfunction : hits

    // Bus decode; a request waits exactly one cycle, then completes.
    assign idx = avs_address[9:2];
    assign aligned = (avs_address[1:0] == 2'b00);
    assign busy = (avs_read || avs_write) && !state_ff.ack;
    assign avs_waitrequest = busy;
    assign wr_take = avs_write && state_ff.ack;
    assign rd_take = avs_read && state_ff.ack;
    assign value_read = rd_take && hits(idx, aligned, IDX_VALUE);

    // The overlimit input only counts when its pin function is enabled.
    assign ovl_asserted = state_ff.cfg[CFG_OVL_EN_BIT] && !thermal_overlimit_line_n;

    // Read multiplexer; unmapped or misaligned addresses read as zero.
    always_comb begin
        rd_mux = ZERO_RST;
        if (hits(idx, aligned, IDX_CFG)) begin
            rd_mux = state_ff.cfg;
        end else if (hits(idx, aligned, IDX_VALUE)) begin
            rd_mux = timer_value;
        end else if (hits(idx, aligned, IDX_LIMIT)) begin
            rd_mux = state_ff.limit;
        end else if (hits(idx, aligned, IDX_PPR)) begin
            rd_mux = state_ff.ppr;
        end else if (hits(idx, aligned, IDX_STATUS)) begin
            rd_mux = state_ff.status;
        end else if (hits(idx, aligned, IDX_MASK)) begin
            rd_mux = state_ff.mask;
        end else if (hits(idx, aligned, IDX_LOCK)) begin
            rd_mux = {7'h00, state_ff.lock};
        end
    end

    // Next state. Read data is captured in the waiting cycle and stands while waitrequest is low.
    always_comb begin
        nxt_state = state_ff;
        nxt_state.ack = busy;
        if (busy) begin
            nxt_state.rdata = {24'h00_0000, rd_mux};
        end
        if (wr_take) begin
            if (hits(idx, aligned, IDX_CFG)) begin
                if (state_ff.lock) begin
                    nxt_state.cfg = (state_ff.cfg & CFG_LOCKABLE) | (avs_writedata[7:0] & ~CFG_LOCKABLE);
                end else begin
                    nxt_state.cfg = avs_writedata[7:0] & CFG_WRITABLE;
                end
            end else if (hits(idx, aligned, IDX_LIMIT)) begin
                nxt_state.limit = avs_writedata[7:0];
            end else if (hits(idx, aligned, IDX_PPR)) begin
                nxt_state.ppr = avs_writedata[7:0];
            end else if (hits(idx, aligned, IDX_MASK)) begin
                nxt_state.mask = avs_writedata[7:0];
            end else if (hits(idx, aligned, IDX_LOCK)) begin
                nxt_state.lock = state_ff.lock | avs_writedata[LOCK_BIT];
            end
        end
        // Only bits that were returned are cleared, so an event caught after capture is kept.
        if (rd_take && hits(idx, aligned, IDX_STATUS)) begin
            nxt_state.status = state_ff.status & ~state_ff.rdata[7:0];
        end
        // Sets come last so an event in the clearing cycle wins.
        if (assert_event) begin
            nxt_state.status[ST_ASSERT_BIT] = 1'b1;
        end
        if (overtime_event) begin
            nxt_state.status[ST_OVERTIME_BIT] = 1'b1;
        end
    end

    // State register.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_ff.cfg <= CFG_RST;
            state_ff.ppr <= PPR_RST;
            state_ff.limit <= LIMIT_RST;
            state_ff.status <= ZERO_RST;
            state_ff.mask <= ZERO_RST;
            state_ff.lock <= 1'b0;
            state_ff.ack <= 1'b0;
            state_ff.rdata <= 32'h0000_0000;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign avs_readdata = state_ff.rdata;

    // A mask bit of one hides its status bit from the interrupt.
    assign irq = |(state_ff.status & ~state_ff.mask);

    // Shared pin: open-drain active-low alert, or push-pull fan drive.
    assign shared_pin_out = state_ff.cfg[CFG_ALERT_BIT] ? 1'b0 : second_fan_drive_output;
    assign shared_pin_oe = state_ff.cfg[CFG_ALERT_BIT] ? irq : 1'b1;

    // Pin function and measurement mode levels.
    assign overlimit_pin_enable = state_ff.cfg[CFG_OVL_EN_BIT];
    assign voltage_monitor_enable = !state_ff.cfg[CFG_OVL_EN_BIT];
    assign fast_rate = state_ff.cfg[CFG_FAST_BIT];
    assign continuous_measure_one = state_ff.cfg[CFG_CONT_LSB];
    assign continuous_measure_two = state_ff.cfg[CFG_CONT_LSB + 1];
    assign continuous_measure_three = state_ff.cfg[CFG_CONT_LSB + 2];
    assign continuous_measure_four = state_ff.cfg[CFG_CONT_LSB + 3];

    // Pulses counted per revolution for each fan.
    assign pulse_count_first_fan = fttc_ppr_pulses(state_ff.ppr[1:0]);
    assign pulse_count_second_fan = fttc_ppr_pulses(state_ff.ppr[3:2]);
    assign pulse_count_third_fan = fttc_ppr_pulses(state_ff.ppr[5:4]);
    assign pulse_count_fourth_fan = fttc_ppr_pulses(state_ff.ppr[7:6]);

    // Overlimit duration timer.
    fttc_ovl_timer #(
        .STEP_CYC(STEP_CYC)
    ) u_timer (
        .clock(clock),
        .arst_n(arst_n),
        .asserted(ovl_asserted),
        .value_read(value_read),
        .limit(state_ff.limit),
        .value(timer_value),
        .assert_event(assert_event),
        .overtime_event(overtime_event)
    );

    // Measurement rate generator.
    fttc_rate_gen #(
        .SLOW_CYC(SLOW_CYC),
        .FAST_CYC(FAST_CYC)
    ) u_rate (
        .clock(clock),
        .arst_n(arst_n),
        .fast(state_ff.cfg[CFG_FAST_BIT]),
        .cont(state_ff.cfg[CFG_CONT_LSB +: 4]),
        .measure_start(measure_start),
        .pulse_stretch_enable(pulse_stretch_enable)
    );

    // Assertions on the pin mux, lock, status and bus timing.
    a_alert_pin_mode: assert property (@(posedge clock) disable iff (!arst_n)
        state_ff.cfg[CFG_ALERT_BIT] |-> !shared_pin_out && (shared_pin_oe == irq))
        else $error("Shared pin not acting as alert.");
    a_fan_pin_mode: assert property (@(posedge clock) disable iff (!arst_n)
        !state_ff.cfg[CFG_ALERT_BIT] |-> shared_pin_oe && (shared_pin_out == second_fan_drive_output))
        else $error("Shared pin not acting as fan drive.");
    a_ovl_gating: assert property (@(posedge clock) disable iff (!arst_n)
        !overlimit_pin_enable |=> !u_timer.state_ff.assert_ev) else $error("Disabled overlimit input counted.");
    a_cont_no_stretch: assert property (@(posedge clock) disable iff (!arst_n)
        continuous_measure_one |-> !pulse_stretch_enable[0] && !measure_start[0])
        else $error("Continuous channel still stretched.");
    a_lock_low_bits: assert property (@(posedge clock) disable iff (!arst_n)
        wr_take && state_ff.lock && hits(idx, aligned, IDX_CFG) |=>
        (state_ff.cfg[3:0] == $past(state_ff.cfg[3:0])) && (state_ff.cfg[7:4] == $past(avs_writedata[7:4])))
        else $error("Locked config bits changed.");
    a_overtime_status: assert property (@(posedge clock) disable iff (!arst_n)
        overtime_event |=> state_ff.status[ST_OVERTIME_BIT]) else $error("Overtime did not set status.");
    a_ppr_default: assert property (@(posedge clock) disable iff (!arst_n)
        (state_ff.ppr[1:0] == 2'b01) |-> (pulse_count_first_fan == 3'h2)) else $error("Default pulse count wrong.");
    a_value_clear: assert property (@(posedge clock) disable iff (!arst_n)
        value_read && !ovl_asserted && (timer_value < SHOW_COUNT_MIN) |=> !timer_value[0])
        else $error("Timer flag not cleared by read.");
    a_wait_one: assert property (@(posedge clock) disable iff (!arst_n)
        busy |=> !avs_waitrequest) else $error("Waitrequest held longer than one cycle.");

    c_cfg_write: cover property (@(posedge clock) disable iff (!arst_n) wr_take && hits(idx, aligned, IDX_CFG));
    c_status_irq: cover property (@(posedge clock) disable iff (!arst_n) irq && state_ff.cfg[CFG_ALERT_BIT]);
endmodule : fttc_regs
`default_nettype wire

// ===== fttc_fan_side.sv
// Far-side model: overlimit line source and fan-two drive source.
`timescale 1ns/1ns
`default_nettype none
module fttc_fan_side (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic overlimit_request,
    input wire logic continuous_measure_two,
    output logic thermal_overlimit_line_n,
    output logic second_fan_drive_output
);
    logic [2:0] pwm_ff;
    // Free count that shapes a slow pulse-width drive for fan two.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pwm_ff <= 3'h0;
        end else begin
            pwm_ff <= pwm_ff + 3'h1;
        end
    end
    // A fan measured continuously must see a dc drive, so the wave is held high then.
    assign second_fan_drive_output = continuous_measure_two | pwm_ff[2];
    // The line is active low and driven hard both ways, so it never floats.
    assign thermal_overlimit_line_n = ~overlimit_request;
endmodule : fttc_fan_side
`default_nettype wire

// ===== fttc_regs_test.sv
// Self-checking bench for the fan and overlimit register bank.
`timescale 1ns/1ns
`default_nettype none
module fttc_regs_test;
    import fttc_pkg::*;
    localparam int STEP = 20;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic ovl_req = 1'b0;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, irq, line_n, fan_drive, pin_out, pin_oe, ovl_en, vmon_en, fast, c1, c2, c3, c4;
    logic [3:0] mstart, stretch;
    logic [2:0] p1, p2, p3, p4;
    logic [7:0] cfg, ppr;
    int fail_count = 0;
    int samples_checked = 0;
    int seed = 32'h06cc;
    int g;

    // Free-running clock at 100 MHz.
    always #5 clock = ~clock;

    fttc_regs #(.STEP_CYC(STEP), .SLOW_CYC(40), .FAST_CYC(10)) DUT (.clock(clock), .arst_n(arst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
        .thermal_overlimit_line_n(line_n), .second_fan_drive_output(fan_drive), .shared_pin_out(pin_out),
        .shared_pin_oe(pin_oe), .overlimit_pin_enable(ovl_en), .voltage_monitor_enable(vmon_en),
        .fast_rate(fast), .continuous_measure_one(c1), .continuous_measure_two(c2),
        .continuous_measure_three(c3), .continuous_measure_four(c4), .measure_start(mstart),
        .pulse_stretch_enable(stretch), .pulse_count_first_fan(p1), .pulse_count_second_fan(p2),
        .pulse_count_third_fan(p3), .pulse_count_fourth_fan(p4));

    fttc_fan_side partner (.clock(clock), .arst_n(arst_n), .overlimit_request(ovl_req),
        .continuous_measure_two(c2), .thermal_overlimit_line_n(line_n), .second_fan_drive_output(fan_drive));

    // Prints the counts and the verdict, then stops.
    task automatic end_sim;
        $display("Checked %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One bus access; the request is held until waitrequest is seen low at a rising edge.
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        int n;
        @(posedge clock);
        avs_address <= {idx, 2'b00};
        avs_read <= ~wr;
        avs_write <= wr;
        avs_writedata <= {24'h00_0000, d};
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        // Read data and release belong to the edge at which waitrequest is seen low.
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 20) begin
            fail_count++;
            end_sim();
        end
    endtask : bus

    task automatic rdchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(name, exp, rd);
    endtask : rdchk

    // Cycles between two start pulses of one channel; 60 means none came.
    task automatic gap(input int ch);
        @(negedge clock);
        for (int n = 0; n < 60 && mstart[ch] !== 1'b1; n++) @(negedge clock);
        g = 0;
        do begin
            @(negedge clock);
            g++;
        end while (mstart[ch] !== 1'b1 && g < 60);
    endtask : gap

    // Holds the overlimit line asserted for n cycles, then lets the events land.
    task automatic hold(input int n);
        @(posedge clock);
        ovl_req <= 1'b1;
        repeat (n) @(posedge clock);
        ovl_req <= 1'b0;
        repeat (4) @(posedge clock);
        @(negedge clock);
    endtask : hold

    function automatic logic [11:0] exp_pulses(input logic [7:0] f);
        for (int i = 0; i < 4; i++) exp_pulses[3*i+:3] = {1'b0, f[2*i+:2]} + 3'h1;
    endfunction : exp_pulses

    initial begin
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        // Reset values, and an unmapped place that reads zero.
        rdchk("cfg", IDX_CFG, 32'h0000_0000);
        rdchk("value", IDX_VALUE, 32'h0000_0000);
        rdchk("limit", IDX_LIMIT, 32'h0000_00ff);
        rdchk("ppr", IDX_PPR, 32'h0000_0055);
        rdchk("unmapped", 8'h10, 32'h0000_0000);
        chk("pulses", 32'h0000_0492, {20'h0_0000, p4, p3, p2, p1});
        // Random settings with both extremes first; the reserved bit is kept clear.
        for (int i = 0; i < 8; i++) begin
            cfg = (i == 0) ? CFG_WRITABLE : (i == 1) ? 8'h00 : 8'($random(seed)) & CFG_WRITABLE;
            ppr = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
            bus(1'b1, IDX_CFG, cfg);
            bus(1'b1, IDX_PPR, ppr);
            rdchk("cfg", IDX_CFG, {24'h00_0000, cfg});
            rdchk("ppr", IDX_PPR, {24'h00_0000, ppr});
            @(negedge clock);
            chk("pulses", {20'h0_0000, exp_pulses(ppr)}, {20'h0_0000, p4, p3, p2, p1});
            chk("modes", {25'h0, cfg[7:3], cfg[1], ~cfg[1]}, {25'h0, c4, c3, c2, c1, fast, ovl_en, vmon_en});
            chk("stretch", {28'h000_0000, ~cfg[7:4]}, {28'h000_0000, stretch});
            chk("pin", {30'h0, cfg[0] ? 2'b00 : {fan_drive, 1'b1}}, {30'h0, pin_out, pin_oe});
        end
        // Measurement rate, slow then fast, with one channel continuous.
        bus(1'b1, IDX_CFG, 8'h40);
        gap(0);
        chk("slow", 40, g);
        gap(2);
        chk("cont", 60, g);
        bus(1'b1, IDX_CFG, 8'h48);
        gap(0);
        chk("fast", 10, g);
        // Limit zero alerts at once; the alert pin follows the interrupt.
        bus(1'b1, IDX_CFG, 8'h03);
        bus(1'b1, IDX_MASK, 8'h00);
        bus(1'b1, IDX_LIMIT, 8'h00);
        hold(3);
        chk("irq", {31'h0, 1'b1}, {31'h0, irq});
        chk("pin", 32'h0000_0001, {30'h0, pin_out, pin_oe});
        rdchk("status", IDX_STATUS, 32'h0000_0021);
        @(negedge clock);
        chk("irq", 32'h0000_0000, {31'h0, irq});
        rdchk("value", IDX_VALUE, 32'h0000_0001);
        rdchk("value", IDX_VALUE, 32'h0000_0000);
        // Long assertion under the top limit, both status bits masked.
        bus(1'b1, IDX_LIMIT, 8'hff);
        bus(1'b1, IDX_MASK, 8'h21);
        hold(5 * STEP + 10);
        chk("irq", 32'h0000_0000, {31'h0, irq});
        rdchk("value", IDX_VALUE, 32'h0000_0005);
        rdchk("status", IDX_STATUS, 32'h0000_0001);
        // Short assertion shows only the flag; the unmasked bit raises the interrupt.
        bus(1'b1, IDX_MASK, 8'h20);
        hold(STEP + STEP / 2);
        chk("irq", 32'h0000_0001, {31'h0, irq});
        rdchk("value", IDX_VALUE, 32'h0000_0001);
        rdchk("status", IDX_STATUS, 32'h0000_0001);
        // A low limit is passed within the same length of assertion.
        bus(1'b1, IDX_LIMIT, 8'h02);
        hold(5 * STEP + 10);
        rdchk("status", IDX_STATUS, 32'h0000_0021);
        rdchk("value", IDX_VALUE, 32'h0000_0005);
        hold(300 * STEP);
        rdchk("value", IDX_VALUE, 32'h0000_00ff);
        // After locking only the continuous-measure bits still take writes.
        bus(1'b1, IDX_CFG, 8'h09);
        bus(1'b1, IDX_LOCK, 8'h01);
        bus(1'b1, IDX_CFG, 8'hf6);
        rdchk("locked", IDX_CFG, 32'h0000_00f9);
        end_sim();
    end
endmodule : fttc_regs_test
`default_nettype wire
